// ### bench/fl_flash_model.sv
// Behavioural serial flash on the far side of the controller
`timescale 1ns/1ps
module fl_flash_model #(
    parameter int BUSY_NS = 1500
) (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0]  mem [int];
    logic [7:0]  op, sh, dout, d0, d1;
    logic [23:0] a;
    logic [23:0] prot = 24'h100000;
    logic        write_latch_bit = 0, sequential_word_program = 0, bso = 0, busy = 0, rdg = 0, cont = 0;
    int          n = 0, bits = 0, ob = 0;
    initial miso = 0;
    function automatic logic [7:0] rd(input int x);
        return mem.exists(x) ? mem[x] : 8'hFF;
    endfunction
    // Programming only clears bits, as a real array does
    task automatic put(input int x, input logic [7:0] v);
        if (x < prot) mem[x] = v & rd(x);
    endtask
    task automatic wipe(input int lo, input int sz);
        if (lo + sz <= prot) for (int i = lo; i < lo + sz; i++) mem.delete(i);
    endtask
    task automatic act();
        case (op)
            8'h02: if (n == 5) put(a, d0);
            8'hAD: if (n == (cont ? 3 : 6)) begin
                a = cont ? a + 24'd2 : {a[23:1], 1'b0};
                sequential_word_program = 1;
                if (a <= 24'h0FFFFE) begin
                    put(a, d0);
                    put(a + 1, d1);
                end
            end
            8'h20: wipe({a[23:12], 12'h0}, 32'h1000);
            8'h52: wipe({a[23:15], 15'h0}, 32'h8000);
            8'hD8: wipe({a[23:16], 16'h0}, 32'h10000);
            8'h60, 8'hC7: if (n == 1) wipe(0, 32'h100000);
            default: ;
        endcase
        if (op != 8'hAD) write_latch_bit = 0;
        busy = 1;
        busy <= #(BUSY_NS) 1'b0;
    endtask
    always @(negedge cs_n) begin
        n = 0;
        bits = 0;
        rdg = 0;
    end
    always @(posedge sck) if (!cs_n) begin
        sh = {sh[6:0], mosi};
        bits++;
        if (bits == 8) begin
            bits = 0;
            if (n == 0) op = sh;
            if (n == 0) cont = sequential_word_program && sh == 8'hAD;
            if (n > 0 && n < 4 && !cont) a = {a[15:0], sh};
            if (n == (cont ? 1 : 4)) d0 = sh;
            if (n == (cont ? 2 : 5)) d1 = sh;
            n++;
            if ((op == 8'h03 && n == 4) || (op == 8'h0B && n == 5)) begin
                rdg = 1;
                ob = 0;
                dout = rd(a);
            end
        end
    end
    always @(negedge sck) if (rdg && !cs_n) begin
        miso = dout[7];
        dout = {dout[6:0], 1'b0};
        ob++;
        if (ob == 8) begin
            ob = 0;
            a = (a + 24'd1) & 24'h0FFFFF;
            dout = rd(a);
        end
    end
    // No pull on the line: a released output shows the inverse of its last level
    always @(posedge cs_n) miso = ~miso;
    // Busy level only while selected, so a deselected line is not rewritten
    always @(negedge cs_n or busy) if (!cs_n && bso && sequential_word_program) miso = !busy;
    always @(posedge cs_n) if (bits == 0 && n > 0 && !busy) begin
        case (op)
            8'h06: write_latch_bit = 1;
            8'h04: begin
                write_latch_bit = 0;
                sequential_word_program = 0;
            end
            8'h70: bso = 1;
            8'h80: bso = 0;
            default: if (write_latch_bit) act();
        endcase
    end
endmodule

// ### bench/fl_host_asserts.sv
// Pin-level checker for the flash host controller
`timescale 1ns/1ps
module fl_host_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi
);
    logic [2:0] bit_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 3'd0;
        end else if (cs_n) begin
            bit_cnt <= 3'd0;
        end else if ($rose(sck)) begin
            bit_cnt <= bit_cnt + 3'd1;
        end
    end
    property p_sck_sel; sck |-> !cs_n; endproperty
    a_sck_sel: assert property (p_sck_sel) else $error("clock outside frame");
    property p_hi; $rose(sck) |-> sck [*4] ##1 !sck; endproperty
    a_hi: assert property (p_hi) else $error("clock high phase wrong");
    property p_lo; $fell(sck) |-> !sck [*4]; endproperty
    a_lo: assert property (p_lo) else $error("clock low phase short");
    property p_mosi; $rose(sck) |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("data moved at sample edge");
    property p_whole; $rose(cs_n) |-> bit_cnt == 3'd0; endproperty
    a_whole: assert property (p_whole) else $error("frame not whole bytes");
    property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
    a_gap: assert property (p_gap) else $error("frames too close");
    property p_hold; $fell(cs_n) |-> !cs_n [*8]; endproperty
    a_hold: assert property (p_hold) else $error("frame too short");
    property p_first; $fell(cs_n) |-> !sck [*4]; endproperty
    a_first: assert property (p_first) else $error("first edge too early");
    c_frame: cover property ($fell(cs_n) ##[1:600] $rose(cs_n));
    c_byte: cover property (bit_cnt == 3'd7);
    c_long: cover property (!cs_n [*8] ##1 cs_n);
endmodule

bind fl_host fl_host_asserts u_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi));

// ### bench/fl_host_test.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fl_params.svh"
module fl_host_test;
    logic        clk, rst, hsel, hwrite, hrdy, hresp, cs_n, sck, mosi, miso;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, st, rv;
    int          num_errors = 0, n_checks = 0;
    fl_host #(.T_BP_NS(2000), .T_SE_NS(2000), .T_BE_NS(2000), .T_CE_NS(2000)) u_dut (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
    fl_flash_model u_mem (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, ad};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic run(input logic [7:0] op, input logic [2:0] cnt, input logic [23:0] ad,
                       input logic [15:0] wd);
        int k;
        bus(1'b1, `FL_REG_ADDR, {8'h0, ad}, rv);
        bus(1'b1, `FL_REG_WDATA, {16'h0, wd}, rv);
        bus(1'b1, `FL_REG_CMD, {21'h0, cnt, op}, rv);
        st = 0;
        for (k = 0; k < 4000 && st[4] !== 1'b1; k++) bus(1'b0, `FL_REG_STATUS, 0, st);
        chk("done", 1, st[4]);
        bus(1'b0, `FL_REG_RDATA, 0, rv);
        chk("hresp", 0, hresp);
    endtask
    task automatic t_prog();
        run(8'h02, 0, 24'h000123, 16'h00A5);
        chk("prog err", 0, st[1]);
        run(8'h03, 2, 24'h000123, 0);
        chk("read", 32'h0000FFA5, rv);
        run(8'h02, 0, 24'h000123, 16'h005A);
        chk("reprog err", 1, st[1]);
        run(8'h03, 1, 24'h000123, 0);
        chk("kept", 32'hA5, rv);
    endtask
    task automatic t_fast();
        u_mem.mem[24'h0FFFFF] = 8'h3C;
        u_mem.mem[0] = 8'h11;
        run(8'h0B, 3, 24'h0FFFFF, 0);
        chk("fast wrap", 32'h00FF113C, rv);
    endtask
    task automatic t_word();
        run(8'h70, 0, 0, 0);
        chk("busy out", 1, st[3]);
        run(8'hAD, 0, 24'h000201, 16'hBBAA);
        run(8'hAD, 0, 0, 16'hDDCC);
        chk("word mode", 1, st[2]);
        run(8'h05, 1, 0, 0);
        chk("refused", 1, st[1]);
        run(8'h04, 0, 0, 0);
        chk("modes off", 0, st[3:2]);
        run(8'h03, 4, 24'h000200, 0);
        chk("words", 32'hDDCCBBAA, rv);
    endtask
    task automatic t_erase();
        int sz [3] = '{32'h1000, 32'h8000, 32'h10000};
        logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
        for (int i = 0; i < 3; i++) begin
            u_mem.mem[0] = 8'h00;
            u_mem.mem[sz[i]] = 8'h00;
            run(ops[i], 0, 24'(sz[i] - 1), 0);
            run(8'h03, 1, 0, 0);
            chk("erased", 32'hFF, rv);
            run(8'h03, 1, 24'(sz[i]), 0);
            chk("next block", 0, rv);
        end
        u_mem.prot = 24'h0F0000;
        run(8'h02, 0, 24'h0F0000, 16'h0000);
        run(8'h03, 1, 24'h0F0000, 0);
        chk("protected", 32'hFF, rv);
        run(8'hC7, 0, 0, 0);
        run(8'h03, 1, 24'h0FFFFF, 0);
        chk("chip kept", 32'h3C, rv);
        u_mem.prot = 24'h100000;
        run(8'h60, 0, 0, 0);
        run(8'h03, 1, 24'h0FFFFF, 0);
        chk("chip erased", 32'hFF, rv);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // Run needs about 12k cycles; allow well over double
    initial begin
        #1000000;
        num_errors++;
        end_of_test();
    end
    initial begin
        rst = 1;
        hsel = 0;
        htrans = 0;
        hwrite = 0;
        haddr = 0;
        hwdata = 0;
        hsize = 3'b010;
        repeat (8) @(posedge clk);
        rst <= 0;
        t_prog();
        t_fast();
        t_word();
        t_erase();
        end_of_test();
    end
endmodule

// ### rtl/fl_byte_if.sv
// Byte hand-off between frame sequencer and bit shifter
`timescale 1ns/1ps
interface fl_byte_if;
    logic       start;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       done;
    modport ctl (output start, output tx, input rx, input done);
    modport sh (input start, input tx, output rx, output done);
endinterface

// ### rtl/fl_host.sv
// Host controller for a serial flash, commanded over AHB-Lite
`timescale 1ns/1ps
`include "fl_params.svh"
module fl_host #(
    parameter int unsigned T_BP_NS = `FL_T_BP_NS,
    parameter int unsigned T_SE_NS = `FL_T_SE_NS,
    parameter int unsigned T_BE_NS = `FL_T_BE_NS,
    parameter int unsigned T_CE_NS = `FL_T_CE_NS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             cs_n,
    output logic             sck,
    output logic             mosi,
    input  wire logic        miso
);
    localparam int unsigned BP_CYC = (T_BP_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;
    localparam int unsigned SE_CYC = (T_SE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;
    localparam int unsigned BE_CYC = (T_BE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;
    localparam int unsigned CE_CYC = (T_CE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS;

    fl_pkg::fl_state_t state;
    fl_pkg::fl_stage_t stg;
    fl_byte_if         sb ();
    logic              miso_s;
    logic              dp_wr;
    logic [7:0]        dp_addr;
    logic [7:0]        cmd_op;
    logic [2:0]        cmd_nrd;
    logic [23:0]       addr_r;
    logic [15:0]       wdata_r;
    logic [31:0]       rdata;
    logic [7:0]        f_op;
    logic [1:0]        f_naddr;
    logic              f_dum;
    logic [1:0]        f_nw;
    logic [2:0]        f_nr;
    logic [3:0]        idx;
    logic [3:0]        gap_cnt;
    logic [31:0]       timer;
    logic              done_f;
    logic              err;
    logic              sequential_word_program;
    logic              aai_stop;
    logic              bsy_out;
    logic [23:0]       aai_addr;

    fl_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (miso),
        .q   (miso_s)
    );

    fl_shift u_shift (
        .clk    (clk),
        .rst    (rst),
        .miso_s (miso_s),
        .bus    (sb.sh),
        .sck    (sck),
        .mosi   (mosi)
    );

    function automatic logic [7:0] addr_byte(input logic [23:0] a, input logic [3:0] i);
        case (i)
            4'h1:    addr_byte = a[23:16];
            4'h2:    addr_byte = a[15:8];
            default: addr_byte = a[7:0];
        endcase
    endfunction

    // Bus side: zero wait states, always OKAY
    wire        ap      = hsel && htrans[1] && hready;
    wire        idle    = state == fl_pkg::FL_IDLE;
    wire        wr_idle = dp_wr && idle;
    wire        go      = wr_idle && dp_addr == `FL_REG_CMD;
    wire [31:0] status  = {27'h0, done_f, bsy_out, sequential_word_program, err, !idle};
    wire [7:0]  ra      = haddr[7:0];
    wire [31:0] rd_mux  = (ra == `FL_REG_CMD)    ? {21'h0, cmd_nrd, cmd_op} :
                          (ra == `FL_REG_ADDR)   ? {8'h0, addr_r} :
                          (ra == `FL_REG_WDATA)  ? {16'h0, wdata_r} :
                          (ra == `FL_REG_RDATA)  ? rdata :
                          (ra == `FL_REG_STATUS) ? status : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_wr     <= 1'b0;
            dp_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_wr <= ap && hwrite;
            if (ap) begin
                dp_addr <= ra;
            end
            if (ap && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Orders are frozen while a command runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_op  <= 8'h00;
            cmd_nrd <= 3'h0;
            addr_r  <= 24'h0;
            wdata_r <= 16'h0;
        end else if (wr_idle) begin
            if (dp_addr == `FL_REG_CMD) begin
                cmd_op  <= hwdata[7:0];
                cmd_nrd <= (hwdata[10:8] > 3'h4) ? 3'h4 : hwdata[10:8];
            end
            if (dp_addr == `FL_REG_ADDR) begin
                addr_r <= hwdata[23:0];
            end
            if (dp_addr == `FL_REG_WDATA) begin
                wdata_r <= hwdata[15:0];
            end
        end
    end

    // Command classification, taken from the order being started
    wire [7:0] op       = idle ? hwdata[7:0] : cmd_op;
    wire       op_swp   = op == `FL_OP_SWP;
    wire       op_erase = op == `FL_OP_SE || op == `FL_OP_BE32 || op == `FL_OP_BE64 ||
                          op == `FL_OP_CE1 || op == `FL_OP_CE2;
    wire       op_write = op == `FL_OP_BP || op_swp || op_erase;
    wire       op_read  = op == `FL_OP_READ || op == `FL_OP_FAST || op == `FL_OP_STATUS_READ_CMD;
    wire       op_addr  = op == `FL_OP_READ || op == `FL_OP_FAST || op == `FL_OP_BP ||
                          op == `FL_OP_SE || op == `FL_OP_BE32 || op == `FL_OP_BE64 ||
                          (op_swp && !sequential_word_program);
    wire       need_pre = op == `FL_OP_BP || (op_swp && !sequential_word_program);
    wire       need_wen = op_write && !(op_swp && sequential_word_program);
    wire       legal    = !sequential_word_program || op_swp || op == `FL_OP_WRITE_DISABLE_CMD ||
                          (op == `FL_OP_STATUS_READ_CMD && !bsy_out);
    wire       go_ok    = go && legal && !(op_swp && aai_stop);

    // Word program pins the first byte to the even address
    wire [23:0] frm_addr = op_swp ? {addr_r[23:1], 1'b0} : addr_r;
    wire [23:0] cur_word = sequential_word_program ? aai_addr : frm_addr;

    fl_pkg::fl_stage_t first_stg;
    fl_pkg::fl_stage_t next_stg;
    fl_pkg::fl_stage_t ld_stg;
    assign first_stg = need_pre ? fl_pkg::FL_STG_PRE :
                       need_wen ? fl_pkg::FL_STG_WRITE_ENABLE_CMD : fl_pkg::FL_STG_MAIN;
    assign next_stg  = (stg == fl_pkg::FL_STG_PRE)  ? fl_pkg::FL_STG_WRITE_ENABLE_CMD :
                       (stg == fl_pkg::FL_STG_WRITE_ENABLE_CMD) ? fl_pkg::FL_STG_MAIN :
                       fl_pkg::FL_STG_BUSY_OUTPUT_OFF_CMD;
    assign ld_stg    = idle ? first_stg : next_stg;

    wire       ld_pre  = ld_stg == fl_pkg::FL_STG_PRE;
    wire       ld_main = ld_stg == fl_pkg::FL_STG_MAIN;
    wire [7:0] ld_op   = ld_pre ? `FL_OP_READ :
                         (ld_stg == fl_pkg::FL_STG_WRITE_ENABLE_CMD) ? `FL_OP_WRITE_ENABLE_CMD :
                         (ld_stg == fl_pkg::FL_STG_BUSY_OUTPUT_OFF_CMD) ? `FL_OP_BOFF : op;
    wire [1:0] ld_nadr = (ld_pre || (ld_main && op_addr)) ? 2'd3 : 2'd0;
    wire       ld_dum  = ld_main && op == `FL_OP_FAST;
    wire [1:0] ld_nw   = !ld_main ? 2'd0 : (op == `FL_OP_BP) ? 2'd1 : op_swp ? 2'd2 : 2'd0;
    wire [2:0] ld_nrd  = ld_pre ? (op_swp ? 3'd2 : 3'd1) :
                         (ld_main && op_read) ? (idle ? hwdata[10:8] : cmd_nrd) : 3'd0;
    wire [2:0] ld_nr   = (ld_nrd > 3'd4) ? 3'd4 : ld_nrd;

    // Byte layout of the running frame
    wire [3:0] a_end  = 4'd1 + {2'b00, f_naddr};
    wire [3:0] w_beg  = a_end + {3'b000, f_dum};
    wire [3:0] r_beg  = w_beg + {2'b00, f_nw};
    wire [3:0] f_last = r_beg + {1'b0, f_nr} - 4'd1;
    wire [1:0] rpos   = 2'(idx - r_beg);
    wire [7:0] tx_now = (idx == 4'd0) ? f_op :
                        (idx < a_end) ? addr_byte(frm_addr, idx) :
                        (idx >= w_beg && idx < r_beg) ?
                            ((idx == w_beg) ? wdata_r[7:0] : wdata_r[15:8]) : 8'h00;

    // Target bytes must read erased before a byte program or the first word of a word program is let through
    wire pre_ok = (f_nr == 3'd2) ? rdata[15:0] == {`FL_ERASED, `FL_ERASED} :
                  rdata[7:0] == `FL_ERASED;
    wire more   = (stg == fl_pkg::FL_STG_PRE && pre_ok) || stg == fl_pkg::FL_STG_WRITE_ENABLE_CMD ||
                  (stg == fl_pkg::FL_STG_MAIN && cmd_op == `FL_OP_WRITE_DISABLE_CMD && bsy_out);
    wire gap_end  = state == fl_pkg::FL_GAP && gap_cnt == 4'd0;
    wire end_main = gap_end && stg == fl_pkg::FL_STG_MAIN;
    wire do_load  = go_ok || (gap_end && more);

    wire [31:0] wait_cyc = (cmd_op == `FL_OP_BP || cmd_op == `FL_OP_SWP) ? BP_CYC :
                           (cmd_op == `FL_OP_SE) ? SE_CYC :
                           (cmd_op == `FL_OP_BE32 || cmd_op == `FL_OP_BE64) ? BE_CYC :
                           CE_CYC;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stg     <= fl_pkg::FL_STG_MAIN;
            f_op    <= 8'h00;
            f_naddr <= 2'd0;
            f_dum   <= 1'b0;
            f_nw    <= 2'd0;
            f_nr    <= 3'd0;
        end else if (do_load) begin
            stg     <= ld_stg;
            f_op    <= ld_op;
            f_naddr <= ld_nadr;
            f_dum   <= ld_dum;
            f_nw    <= ld_nw;
            f_nr    <= ld_nr;
        end
    end

    // Mode tracking mirrors what the device believes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sequential_word_program      <= 1'b0;
            aai_stop <= 1'b0;
            bsy_out  <= 1'b0;
            aai_addr <= 24'h0;
        end else if (gap_end && stg == fl_pkg::FL_STG_BUSY_OUTPUT_OFF_CMD) begin
            bsy_out <= 1'b0;
        end else if (end_main) begin
            case (cmd_op)
                `FL_OP_BON: begin
                    bsy_out <= 1'b1;
                end
                `FL_OP_BOFF: begin
                    bsy_out <= 1'b0;
                end
                `FL_OP_WRITE_DISABLE_CMD: begin
                    sequential_word_program      <= 1'b0;
                    aai_stop <= 1'b0;
                end
                `FL_OP_SWP: begin
                    sequential_word_program      <= 1'b1;
                    aai_addr <= cur_word + `FL_WORD_STEP;
                    aai_stop <= cur_word == `FL_TOP_WORD;
                end
                default: begin
                    sequential_word_program <= sequential_word_program;
                end
            endcase
        end
    end

    // Frame sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= fl_pkg::FL_IDLE;
            idx      <= 4'h0;
            gap_cnt  <= 4'h0;
            timer    <= 32'h0;
            cs_n     <= 1'b1;
            sb.start <= 1'b0;
            sb.tx    <= 8'h00;
            rdata    <= 32'h0;
            done_f   <= 1'b0;
            err      <= 1'b0;
        end else begin
            sb.start <= 1'b0;
            case (state)
                fl_pkg::FL_IDLE: begin
                    if (go) begin
                        done_f <= !go_ok;
                        err    <= !go_ok;
                        rdata  <= 32'h0;
                        idx    <= 4'h0;
                    end
                    if (go_ok) begin
                        state <= fl_pkg::FL_LOAD;
                    end
                end
                fl_pkg::FL_LOAD: begin
                    cs_n     <= 1'b0;
                    sb.tx    <= tx_now;
                    sb.start <= 1'b1;
                    state    <= fl_pkg::FL_BYTE;
                end
                fl_pkg::FL_BYTE: begin
                    if (sb.done) begin
                        if (idx >= r_beg) begin
                            rdata[{rpos, 3'b000} +: 8] <= sb.rx;
                        end
                        if (idx == f_last) begin
                            // Select only rises on a byte boundary
                            cs_n    <= 1'b1;
                            gap_cnt <= `FL_GAP_CYC;
                            state   <= fl_pkg::FL_GAP;
                        end else begin
                            idx   <= idx + 4'h1;
                            state <= fl_pkg::FL_LOAD;
                        end
                    end
                end
                fl_pkg::FL_GAP: begin
                    if (gap_cnt != 4'h0) begin
                        gap_cnt <= gap_cnt - 4'h1;
                    end else if (more) begin
                        idx   <= 4'h0;
                        state <= fl_pkg::FL_LOAD;
                    end else if (stg == fl_pkg::FL_STG_PRE) begin
                        err    <= 1'b1;
                        done_f <= 1'b1;
                        state  <= fl_pkg::FL_IDLE;
                    end else if (stg == fl_pkg::FL_STG_MAIN && cmd_op == `FL_OP_SWP &&
                                 bsy_out) begin
                        // Settle time so a floating pin is not read as ready
                        cs_n    <= 1'b0;
                        gap_cnt <= `FL_GAP_CYC;
                        state   <= fl_pkg::FL_POLL;
                    end else if (stg == fl_pkg::FL_STG_MAIN && op_write) begin
                        timer <= wait_cyc;
                        state <= fl_pkg::FL_WAIT;
                    end else begin
                        done_f <= 1'b1;
                        state  <= fl_pkg::FL_IDLE;
                    end
                end
                fl_pkg::FL_WAIT: begin
                    if (timer != 32'h0) begin
                        timer <= timer - 32'h1;
                    end else begin
                        done_f <= 1'b1;
                        state  <= fl_pkg::FL_IDLE;
                    end
                end
                fl_pkg::FL_POLL: begin
                    if (gap_cnt != 4'h0) begin
                        gap_cnt <= gap_cnt - 4'h1;
                    end else if (miso_s) begin
                        cs_n   <= 1'b1;
                        done_f <= 1'b1;
                        state  <= fl_pkg::FL_IDLE;
                    end
                end
                default: begin
                    cs_n  <= 1'b1;
                    state <= fl_pkg::FL_IDLE;
                end
            endcase
        end
    end
endmodule

// ### rtl/fl_params.svh
// Constants of the serial flash host controller
`ifndef FL_PARAMS_SVH
`define FL_PARAMS_SVH
`define FL_CLK_NS      10
`define FL_SCK_HALF    3'd4
`define FL_BIT_LAST    3'd7
`define FL_GAP_CYC     4'd8
`define FL_OP_READ     8'h03
`define FL_OP_FAST     8'h0B
`define FL_OP_BP       8'h02
`define FL_OP_SWP      8'hAD
`define FL_OP_SE       8'h20
`define FL_OP_BE32     8'h52
`define FL_OP_BE64     8'hD8
`define FL_OP_CE1      8'h60
`define FL_OP_CE2      8'hC7
`define FL_OP_WRITE_ENABLE_CMD     8'h06
`define FL_OP_WRITE_DISABLE_CMD     8'h04
`define FL_OP_STATUS_READ_CMD     8'h05
`define FL_OP_BON      8'h70
`define FL_OP_BOFF     8'h80
`define FL_TOP_WORD    24'h0FFFFE
`define FL_WORD_STEP   24'h000002
`define FL_ERASED      8'hFF
`define FL_REG_CMD     8'h00
`define FL_REG_ADDR    8'h04
`define FL_REG_WDATA   8'h08
`define FL_REG_RDATA   8'h0C
`define FL_REG_STATUS  8'h10
`define FL_T_BP_NS     10000
`define FL_T_SE_NS     25000000
`define FL_T_BE_NS     25000000
`define FL_T_CE_NS     50000000
`endif

// ### rtl/fl_pkg.sv
// Types of the serial flash host controller
package fl_pkg;
    typedef enum logic [2:0] {
        FL_IDLE = 3'b000,
        FL_LOAD = 3'b001,
        FL_BYTE = 3'b010,
        FL_GAP  = 3'b011,
        FL_WAIT = 3'b100,
        FL_POLL = 3'b101
    } fl_state_t;
    typedef enum logic [1:0] {
        FL_STG_PRE  = 2'b00,
        FL_STG_WRITE_ENABLE_CMD = 2'b01,
        FL_STG_MAIN = 2'b10,
        FL_STG_BUSY_OUTPUT_OFF_CMD = 2'b11
    } fl_stage_t;
endpackage

// ### rtl/fl_shift.sv
// Mode 0 byte shifter with serial clock divider
`timescale 1ns/1ps
`include "fl_params.svh"
module fl_shift (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic miso_s,
    fl_byte_if.sh     bus,
    output logic      sck,
    output logic      mosi
);
    logic [2:0] div;
    logic [2:0] cnt;
    logic [7:0] sr;
    logic       active;
    wire        tick = active && (div == `FL_SCK_HALF - 3'd1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div      <= 3'h0;
            cnt      <= 3'h0;
            sr       <= 8'h00;
            active   <= 1'b0;
            sck      <= 1'b0;
            mosi     <= 1'b0;
            bus.rx   <= 8'h00;
            bus.done <= 1'b0;
        end else begin
            bus.done <= 1'b0;
            div      <= (!active || tick) ? 3'h0 : div + 3'h1;
            if (bus.start) begin
                active <= 1'b1;
                sr     <= bus.tx;
                mosi   <= bus.tx[7];
                cnt    <= 3'h0;
                sck    <= 1'b0;
            end else if (tick && !sck) begin
                sck    <= 1'b1;
                bus.rx <= {bus.rx[6:0], miso_s};
            end else if (tick) begin
                sck <= 1'b0;
                if (cnt == `FL_BIT_LAST) begin
                    active   <= 1'b0;
                    bus.done <= 1'b1;
                end else begin
                    sr   <= {sr[6:0], 1'b0};
                    mosi <= sr[6];
                    cnt  <= cnt + 3'h1;
                end
            end
        end
    end
endmodule

// ### rtl/fl_sync.sv
// Two-flop synchroniser for the flash data input
`timescale 1ns/1ps
module fl_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
